// ### row_miss_ctrl.sv
// row fetch, retry holdoff, burst refresh and address swap logic of a DRAM slave
//
// Local design decisions: the placing of the registers and the strobed register port.
`timescale 1ns/10ps

module row_miss_ctrl (
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic                          req_valid,
  input  wire row_miss_pkg::chan_req_t       req,
  output row_miss_pkg::chan_ack_t            ack,
  output logic [32:0]                        mapped_addr,
  input  wire logic [row_miss_pkg::REG_AW-1:0] reg_addr,
  input  wire logic [row_miss_pkg::REG_DW-1:0] reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic [row_miss_pkg::REG_DW-1:0]    reg_rdata
);

  localparam int BW = row_miss_pkg::CNT_W;

  // fixed part plus programmable field, in cycles
  function automatic logic [BW-1:0] core_cyc(input logic [4:0] field);
    core_cyc = row_miss_pkg::CORE_FIXED_CYC + {6'h00, field};
  endfunction

  // per-bit exchange of the two nine-bit fields
  function automatic logic [32:0] swap_map(input logic [32:0] a, input logic [8:0] sel);
    logic [32:0] m;
    m = a;
    for (int k = 0; k < 9; k++) begin
      if (sel[k]) begin
        m[17 + k] = a[8 + k];
        m[8 + k]  = a[17 + k];
      end
    end
    swap_map = m;
  endfunction

  row_miss_pkg::row_timing_t                     timing_q;
  logic [8:0]                                    swap_q;
  logic [BW-1:0]                                 retry_q;
  logic [BW-1:0]                                 imp_q;
  logic                                          pend_fill_q;
  logic                                          pend_refresh_q;
  logic                                          pend_bank_q;
  logic [row_miss_pkg::ROW_W-1:0]                pend_row_q;
  logic [row_miss_pkg::NUM_BANKS-1:0]            valid_q;
  logic [row_miss_pkg::NUM_BANKS-1:0]            dirty_q;
  logic [row_miss_pkg::ROW_W-1:0]                row_q [row_miss_pkg::NUM_BANKS];
  logic [32:0]                                   map_w;
  logic                                          bank_w;
  logic [row_miss_pkg::ROW_W-1:0]                row_w;
  logic                                          busy_w;
  logic                                          hit_w;
  logic                                          take_hit;
  logic                                          take_miss;
  logic                                          take_refresh;
  logic                                          fill_done;
  logic                                          refresh_done;
  logic                                          old_dirty_w;
  logic [BW-1:0]                                 t_ovh;
  logic [BW-1:0]                                 t_pre;
  logic [BW-1:0]                                 t_sense;
  logic [BW-1:0]                                 t_imp;
  logic [BW-1:0]                                 t_exp;
  logic [BW-1:0]                                 clean_time;
  logic [BW-1:0]                                 dirty_time;
  logic [BW-1:0]                                 refresh_time;
  logic [BW-1:0]                                 load_w;

  // interval components, all in clock cycles
  assign t_ovh   = row_miss_pkg::ROW_OVERHEAD_CYC;
  assign t_pre   = core_cyc(timing_q.precharge);
  assign t_sense = core_cyc(timing_q.sense);
  assign t_imp   = core_cyc(timing_q.imp_restore);
  assign t_exp   = core_cyc(timing_q.exp_restore);

  // retry totals
  assign clean_time = t_ovh + t_pre + t_sense;
  assign dirty_time = t_ovh + t_exp + t_pre + t_sense;
  assign old_dirty_w = |(dirty_q & valid_q);
  assign refresh_time = t_ovh + (old_dirty_w ? t_exp : '0) + (t_pre << 1) + t_sense
                      + BW'((t_ovh + t_imp + (t_pre << 1) + t_sense)
                            << row_miss_pkg::REFRESH_ROWS_LOG2);

  // address decode of the incoming request
  assign map_w  = swap_map(req.addr, swap_q);
  assign bank_w = map_w[8];
  assign row_w  = map_w[25:9];

  // request classification
  assign busy_w       = (retry_q != '0);
  assign hit_w        = valid_q[bank_w] && (row_q[bank_w] == row_w);
  assign take_refresh = req_valid && !busy_w && req.refresh;
  assign take_hit     = req_valid && !busy_w && !req.refresh && hit_w;
  assign take_miss    = req_valid && !busy_w && !req.refresh && !hit_w;
  assign fill_done    = pend_fill_q && (retry_q == BW'(1));
  assign refresh_done = pend_refresh_q && (retry_q == BW'(1));

  // value loaded into the retry counter, lengthened by a running implicit restore
  always_comb begin
    load_w = '0;
    if (take_refresh) begin
      load_w = refresh_time + imp_q - BW'(1);
    end else if (take_miss) begin
      load_w = ((dirty_q[bank_w] && valid_q[bank_w]) ? dirty_time : clean_time)
             + imp_q - BW'(1);
    end
  end

  // single retry down-counter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      retry_q <= '0;
    end else if (take_miss || take_refresh) begin
      retry_q <= load_w;
    end else if (busy_w) begin
      retry_q <= retry_q - BW'(1);
    end
  end

  // pending operation tracking
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pend_fill_q    <= 1'b0;
      pend_refresh_q <= 1'b0;
      pend_bank_q    <= 1'b0;
      pend_row_q     <= '0;
    end else if (take_miss) begin
      pend_fill_q <= 1'b1;
      pend_bank_q <= bank_w;
      pend_row_q  <= row_w;
    end else if (take_refresh) begin
      pend_refresh_q <= 1'b1;
    end else if (fill_done || refresh_done) begin
      pend_fill_q    <= 1'b0;
      pend_refresh_q <= 1'b0;
    end
  end

  // implicit restore runs beside later transfers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      imp_q <= '0;
    end else if (fill_done) begin
      imp_q <= t_imp;
    end else if (take_miss || take_refresh) begin
      imp_q <= '0; // absorbed into the retry count
    end else if (imp_q != '0) begin
      imp_q <= imp_q - BW'(1);
    end
  end

  // per-bank valid and dirty flags, kept off the channel
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      valid_q <= '0;
      dirty_q <= '0;
    end else if (fill_done) begin
      valid_q[pend_bank_q] <= 1'b1;
      dirty_q[pend_bank_q] <= 1'b0;
    end else if (refresh_done) begin
      dirty_q <= '0;
    end else if (take_hit && req.write && !req.close) begin
      dirty_q[bank_w] <= 1'b1;
    end else if (take_hit && req.close) begin
      dirty_q[bank_w] <= 1'b0;
    end
  end

  // row address registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int b = 0; b < row_miss_pkg::NUM_BANKS; b++) begin
        row_q[b] <= '0;
      end
    end else if (fill_done) begin
      row_q[pend_bank_q] <= pend_row_q;
    end
  end

  // acknowledge, one cycle after the request; requests refused during holdoff are dropped
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack <= '0;
    end else begin
      ack.valid <= req_valid;
      ack.okay  <= take_hit;
      ack.nack  <= req_valid && !take_hit;
    end
  end

  // mapped address of the last okayed request
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mapped_addr <= '0;
    end else if (take_hit) begin
      mapped_addr <= map_w;
    end
  end

  // software writes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      timing_q.precharge   <= row_miss_pkg::RST_PRECHARGE;
      timing_q.sense       <= row_miss_pkg::RST_SENSE;
      timing_q.imp_restore <= row_miss_pkg::RST_IMP_RESTORE;
      timing_q.exp_restore <= row_miss_pkg::RST_EXP_RESTORE;
      swap_q               <= row_miss_pkg::RST_SWAP_SELECT;
    end else if (reg_wr) begin
      if (reg_addr == row_miss_pkg::OFF_ROW_TIMING) begin
        timing_q.precharge   <= reg_wdata[row_miss_pkg::POS_PRECHARGE +: 5];
        timing_q.sense       <= reg_wdata[row_miss_pkg::POS_SENSE +: 5];
        timing_q.imp_restore <= reg_wdata[row_miss_pkg::POS_IMP_RESTORE +: 5];
        timing_q.exp_restore <= reg_wdata[row_miss_pkg::POS_EXP_RESTORE +: 5];
      end
      if (reg_addr == row_miss_pkg::OFF_SWAP_SELECT) begin
        swap_q <= reg_wdata[8:0];
      end
    end
  end

  // software reads, data in the following cycle; unmapped reads zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= '0;
      unique case (reg_addr)
        row_miss_pkg::OFF_ROW_TIMING: begin
          reg_rdata[row_miss_pkg::POS_PRECHARGE +: 5]   <= timing_q.precharge;
          reg_rdata[row_miss_pkg::POS_SENSE +: 5]       <= timing_q.sense;
          reg_rdata[row_miss_pkg::POS_IMP_RESTORE +: 5] <= timing_q.imp_restore;
          reg_rdata[row_miss_pkg::POS_EXP_RESTORE +: 5] <= timing_q.exp_restore;
        end
        row_miss_pkg::OFF_SWAP_SELECT: begin
          reg_rdata[8:0] <= swap_q;
        end
        row_miss_pkg::OFF_STATUS: begin
          reg_rdata[row_miss_pkg::POS_ST_BUSY]        <= busy_w;
          reg_rdata[row_miss_pkg::POS_ST_IMP_BUSY]    <= (imp_q != '0);
          reg_rdata[row_miss_pkg::POS_ST_REFRESH]     <= pend_refresh_q;
          reg_rdata[row_miss_pkg::POS_ST_COUNT +: BW] <= retry_q;
        end
        default: begin
          reg_rdata <= '0;
        end
      endcase
    end
  end

  // checks
  AST_MISS_NACK: assert property (@(posedge clk) disable iff (rst)
    take_miss |=> ack.valid && ack.nack && !ack.okay && busy_w)
    else $error("miss was not refused with a fetch started");

  AST_BUSY_NACK: assert property (@(posedge clk) disable iff (rst)
    req_valid && busy_w |=> ack.nack && !ack.okay)
    else $error("request during holdoff was not refused");

  AST_FILL_VALID: assert property (@(posedge clk) disable iff (rst)
    fill_done |=> valid_q[$past(pend_bank_q)] && !busy_w
                  && row_q[$past(pend_bank_q)] == $past(pend_row_q))
    else $error("fetched row not installed as valid");

  AST_WRITE_DIRTY: assert property (@(posedge clk) disable iff (rst)
    take_hit && req.write && !req.close |=> dirty_q[$past(bank_w)])
    else $error("write hit did not mark the bank dirty");

  AST_CLEAN_TIME: assert property (@(posedge clk) disable iff (rst)
    take_miss && !(dirty_q[bank_w] && valid_q[bank_w]) && imp_q == '0
      |=> retry_q == $past(clean_time) - BW'(1))
    else $error("clean retry count wrong");

  AST_DIRTY_TIME: assert property (@(posedge clk) disable iff (rst)
    take_miss && dirty_q[bank_w] && valid_q[bank_w] && imp_q == '0
      |=> retry_q == $past(dirty_time) - BW'(1))
    else $error("dirty retry count wrong");

  AST_REFRESH_HOLD: assert property (@(posedge clk) disable iff (rst)
    take_refresh |=> busy_w [*8])
    else $error("refresh holdoff ended too early");

  AST_REFRESH_CLEAR: assert property (@(posedge clk) disable iff (rst)
    refresh_done |=> dirty_q == '0 && valid_q == $past(valid_q))
    else $error("refresh altered cached row state");

  AST_PASS_FIELDS: assert property (@(posedge clk) disable iff (rst)
    map_w[32:26] == req.addr[32:26] && map_w[7:0] == req.addr[7:0])
    else $error("top or column field altered by mapping");

  AST_FULL_SWAP: assert property (@(posedge clk) disable iff (rst)
    swap_q == 9'h1FF |-> map_w[25:17] == req.addr[16:8] && map_w[16:8] == req.addr[25:17])
    else $error("full swap did not exchange fields");

  AST_RESUME_OKAY: assert property (@(posedge clk) disable iff (rst)
    fill_done ##1 (req_valid && !req.refresh && map_w[8] == $past(pend_bank_q, 2)
      && map_w[25:9] == $past(pend_row_q, 2)) |=> ack.okay)
    else $error("reissued request after fetch not accepted");

  AST_ACK_ONE: assert property (@(posedge clk) disable iff (rst)
    ack.valid == (ack.okay || ack.nack) && !(ack.okay && ack.nack))
    else $error("acknowledge not exactly one of okay and nack");

  AST_IMP_EXTEND: assert property (@(posedge clk) disable iff (rst)
    take_miss && !(dirty_q[bank_w] && valid_q[bank_w])
      |=> retry_q == $past(clean_time) + $past(imp_q) - BW'(1))
    else $error("running restore did not lengthen the retry");

  AST_REFRESH_TIME: assert property (@(posedge clk) disable iff (rst)
    take_refresh && imp_q == '0
      |=> retry_q == $past(t_ovh + (old_dirty_w ? t_exp : '0) + t_pre + t_pre + t_sense
                           + ((t_ovh + t_imp + t_pre + t_pre + t_sense) << 2)) - BW'(1))
    else $error("refresh retry count wrong");

  AST_REFUSED_DROP: assert property (@(posedge clk) disable iff (rst)
    req_valid && busy_w && !fill_done && !refresh_done
      |=> $stable(valid_q) && $stable(dirty_q) && $stable(pend_row_q)
          && $stable(mapped_addr))
    else $error("refused request changed device state");

  AST_FILL_CLEAN: assert property (@(posedge clk) disable iff (rst)
    fill_done |=> !dirty_q[$past(pend_bank_q)])
    else $error("refilled bank left dirty");

  AST_CLOSE_CLEAN: assert property (@(posedge clk) disable iff (rst)
    take_hit && req.close |=> !dirty_q[$past(bank_w)])
    else $error("closing access left the bank dirty");

  AST_COUNT_DOWN: assert property (@(posedge clk) disable iff (rst)
    busy_w |=> retry_q == $past(retry_q) - BW'(1))
    else $error("retry counter did not step down");

  AST_HIT_MAP: assert property (@(posedge clk) disable iff (rst)
    take_hit |=> mapped_addr == $past(map_w))
    else $error("okayed request did not publish its mapped address");

  COV_CLEAN_MISS: cover property (@(posedge clk) disable iff (rst)
    take_miss && !dirty_q[bank_w] ##[1:300] fill_done);
  COV_DIRTY_MISS: cover property (@(posedge clk) disable iff (rst)
    take_miss && dirty_q[bank_w] && valid_q[bank_w]);
  COV_REFRESH: cover property (@(posedge clk) disable iff (rst)
    take_refresh ##[1:1000] refresh_done);
  COV_WRITE_HIT: cover property (@(posedge clk) disable iff (rst)
    take_hit && req.write);
  COV_IMP_EXTEND: cover property (@(posedge clk) disable iff (rst)
    take_miss && imp_q != '0);

endmodule // row_miss_ctrl

// ### row_miss_pkg.sv
// shared constants and carrier types for the row fetch and address map block
package row_miss_pkg;

  // register port geometry
  localparam int          REG_AW            = 8;
  localparam int          REG_DW            = 32;
  localparam logic [7:0]  OFF_ROW_TIMING    = 8'h00;
  localparam logic [7:0]  OFF_SWAP_SELECT   = 8'h04;
  localparam logic [7:0]  OFF_STATUS        = 8'h08;

  // row timing register field positions (lsb of each 5-bit field)
  localparam int          POS_PRECHARGE     = 0;
  localparam int          POS_SENSE         = 5;
  localparam int          POS_IMP_RESTORE   = 10;
  localparam int          POS_EXP_RESTORE   = 15;

  // row timing reset values, programmable parts
  localparam logic [4:0]  RST_PRECHARGE     = 5'h01;
  localparam logic [4:0]  RST_SENSE         = 5'h07;
  localparam logic [4:0]  RST_IMP_RESTORE   = 5'h0A;
  localparam logic [4:0]  RST_EXP_RESTORE   = 5'h04;
  localparam logic [8:0]  RST_SWAP_SELECT   = 9'h000;

  // status register field positions
  localparam int          POS_ST_BUSY       = 0;
  localparam int          POS_ST_IMP_BUSY   = 1;
  localparam int          POS_ST_REFRESH    = 2;
  localparam int          POS_ST_COUNT      = 16;

  // fixed interval parts in clock cycles
  localparam logic [10:0] ROW_OVERHEAD_CYC  = 11'h006;
  localparam logic [10:0] CORE_FIXED_CYC    = 11'h004;
  localparam int          REFRESH_ROWS_LOG2 = 2;  // four rows per burst

  // memory organisation
  localparam int          NUM_BANKS         = 2;
  localparam int          ROW_W             = 17;
  localparam int          CNT_W             = 11;

  // programmable parts of the core intervals
  typedef struct packed {
    logic [4:0] exp_restore;
    logic [4:0] imp_restore;
    logic [4:0] sense;
    logic [4:0] precharge;
  } row_timing_t;

  // channel request as seen by the device
  typedef struct packed {
    logic [32:0] addr;     // octbyte address bits 35:3
    logic        write;
    logic        close;
    logic        refresh;
  } chan_req_t;

  // acknowledge returned one cycle after the request
  typedef struct packed {
    logic valid;
    logic okay;
    logic nack;
  } chan_ack_t;

endpackage

// ### row_miss_master.sv
// channel master model: issues requests and retries refused ones
`timescale 1ns/10ps

module row_miss_master (
  input  wire logic                    clk,
  output logic                         req_valid,
  output row_miss_pkg::chan_req_t      req,
  input  wire row_miss_pkg::chan_ack_t ack
);

  // quiet channel from time zero
  initial begin
    req_valid = 1'b0;
    req       = '0;
  end

  // one request from just after an edge, ack taken two edges on
  task automatic send(input  row_miss_pkg::chan_req_t r,
                      output int                      t,
                      output row_miss_pkg::chan_ack_t a);
    t = int'($realtime / 25.0 + 0.25);
    req_valid <= 1'b1;
    req       <= r;
    @(posedge clk);
    req_valid <= 1'b0;
    req       <= ~r;  // released lines show no stale value
    @(posedge clk);
    a = ack;
  endtask

  // the whole request again after each refusal, gap + 1 idle cycles between
  task automatic access(input  row_miss_pkg::chan_req_t r,
                        input  int                      gap,
                        output int                      t_first,
                        output int                      t_ok,
                        output int                      n_bad);
    row_miss_pkg::chan_ack_t a;
    int                      t;
    n_bad = 0;
    t_ok  = -1;
    for (int i = 0; i < 500 && t_ok < 0; i++) begin
      send(r, t, a);
      if (i == 0) t_first = t;
      if (a.valid !== 1'b1 || (a.okay ^ a.nack) !== 1'b1) n_bad++;
      if (a.okay === 1'b1) t_ok = t;
      else repeat (gap) @(posedge clk);
    end
  endtask

endmodule // row_miss_master

// ### test_row_miss_retry_and_address_map.sv
// self-checking bench: reference model against the row fetch and swap block
`timescale 1ns/10ps

module test_row_miss_retry_and_address_map;
  logic                            clk;
  logic                            rst;
  logic                            req_valid;
  row_miss_pkg::chan_req_t         req;
  row_miss_pkg::chan_ack_t         ack;
  logic [32:0]                     mapped_addr;
  logic [row_miss_pkg::REG_AW-1:0] reg_addr;
  logic [row_miss_pkg::REG_DW-1:0] reg_wdata;
  logic                            reg_wr;
  logic                            reg_rd;
  logic [row_miss_pkg::REG_DW-1:0] reg_rdata;
  int                              n_errors;
  int                              n_compared;
  int                              pre, sen, imp, exr, swp;
  int                              fill_at, imp_left;
  bit   [1:0]                      vld, drt;
  int                              row [2];
  logic [32:0]                     pool [4];

  row_miss_ctrl i_dut (
    .clk         (clk),
    .rst         (rst),
    .req_valid   (req_valid),
    .req         (req),
    .ack         (ack),
    .mapped_addr (mapped_addr),
    .reg_addr    (reg_addr),
    .reg_wdata   (reg_wdata),
    .reg_wr      (reg_wr),
    .reg_rd      (reg_rd),
    .reg_rdata   (reg_rdata)
  );

  row_miss_master i_master (
    .clk       (clk),
    .req_valid (req_valid),
    .req       (req),
    .ack       (ack)
  );

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // value comparison
  task automatic cmp_data(input logic [32:0] got, input logic [32:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected data at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // cycle count comparison
  task automatic cmp_cycles(input int got, input int exp);
    n_compared++;
    if (got != exp) begin
      n_errors++;
      $display("unexpected cycles at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // register write, then a quiet edge
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask

  // register read, data taken in the cycle after the strobe
  task automatic reg_check(input logic [7:0] a, input logic [31:0] exp);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    cmp_data(33'(reg_rdata), 33'(exp));
  endtask

  function automatic logic [31:0] tw();
    return 32'((exr << 15) | (imp << 10) | (sen << 5) | pre);
  endfunction

  // bit k of the upper field trades places with bit k of the lower
  function automatic logic [32:0] swap_map(logic [32:0] a, logic [8:0] s);
    logic [32:0] m;
    m = a;
    for (int k = 0; k < 9; k++) begin
      if (s[k]) begin
        m[17+k] = a[8+k];
        m[8+k]  = a[17+k];
      end
    end
    return m;
  endfunction

  // restore cycles still running at edge x, absorbed by the next miss or refresh
  function automatic int restore_left(input int x);
    int r;
    r = imp_left + 1 - (x - fill_at);
    return r > 0 ? r : 0;
  endfunction

  // every word of the register window; only timing and swap hold ones
  task automatic scan_regs();
    for (int i = 0; i < 64; i++) begin
      reg_check(8'(i * 4), i == 0 ? tw() : i == 1 ? 32'(swp) : 32'h0);
    end
  endtask

  // one access through the master, optionally behind a burst refresh
  task automatic run(input logic [32:0] a, input bit wr, input bit cl, input bit refr);
    row_miss_pkg::chan_ack_t k;
    logic [32:0]             m;
    int                      t0, t1, t_ok, bad, busy, t, step, b, tm, fin;
    step = 2 + $urandom_range(3);  // prompt or slow retries
    m    = swap_map(a, 9'(swp));
    b    = int'(m[8]);
    busy = 0;
    t    = 0;
    tm   = -1;
    fin  = 0;
    if (refr) begin
      i_master.send('{a, 1'b0, 1'b0, 1'b1}, t0, k);
      cmp_data(33'(k.nack), 33'h1);
      busy = 6 + 2 * (4 + pre) + 4 + sen + 4 * (14 + imp + 2 * (4 + pre) + sen)
             + restore_left(t0);
      if ((vld & drt) != 2'b00) busy += 4 + exr;
      drt     = 2'b00;
      fill_at = -1000;  // the refresh swallows a running restore
      t       = 2;
    end
    while (t < busy) t += step;
    if (!vld[b] || row[b] != int'(m[25:9])) begin
      tm     = t;
      fin    = 14 + pre + sen + (vld[b] && drt[b] ? 4 + exr : 0);
      vld[b] = 1'b1;
      row[b] = int'(m[25:9]);
      drt[b] = 1'b0;
    end
    drt[b] = cl ? 1'b0 : drt[b] | wr;
    i_master.access('{a, wr, cl, 1'b0}, step - 2, t1, t_ok, bad);
    if (!refr) t0 = t1;  // retry time counts from the first refused request
    if (tm >= 0) begin
      busy = tm + fin + restore_left(t0 + tm);
      while (t < busy) t += step;
      fill_at  = t0 + busy - 1;
      imp_left = 4 + imp;
    end
    cmp_cycles(t_ok - t0, t);
    cmp_cycles(bad, 0);
    cmp_data(mapped_addr, m);
    repeat ($urandom_range(40)) @(posedge clk);  // restore may still run at the next access
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // hang guard, well beyond the longest refresh-heavy run
  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    print_verdict();
  end

  // main sequence
  initial begin
    logic [32:0] a;
    rst        = 1'b1;
    reg_addr   = 8'h00;
    reg_wdata  = 32'h0;
    reg_wr     = 1'b0;
    reg_rd     = 1'b0;
    n_errors   = 0;
    n_compared = 0;
    {pre, sen, imp, exr, swp} = {32'd1, 32'd7, 32'd10, 32'd4, 32'd0};
    vld = 2'b00;
    drt = 2'b00;
    fill_at  = -1000;
    imp_left = 0;
    void'($urandom(32'he606));
    for (int i = 0; i < 4; i++) pool[i] = {1'($urandom_range(1)), $urandom};
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    scan_regs();
    reg_write(row_miss_pkg::OFF_STATUS, 32'hFFFF_FFFF);
    reg_write(8'h40, 32'hFFFF_FFFF);
    scan_regs();
    $display("test registers done");
    run(33'h0_0000_0200, 1'b0, 1'b0, 1'b0);
    run(33'h0_0000_0200, 1'b1, 1'b0, 1'b0);
    run(33'h0_0000_0400, 1'b1, 1'b1, 1'b0);
    run(33'h0_0000_0200, 1'b1, 1'b0, 1'b0);
    run(33'h0_0000_0100, 1'b0, 1'b0, 1'b1);
    run(33'h0_0000_0400, 1'b0, 1'b0, 1'b0);
    repeat (40) @(posedge clk);  // let the restore drain so status reads idle
    scan_regs();
    swp = 32'h1FF;
    reg_write(row_miss_pkg::OFF_SWAP_SELECT, 32'h0000_01FF);
    run(33'h1_2345_6789, 1'b0, 1'b0, 1'b0);
    $display("test directed done");
    for (int i = 0; i < 40; i++) begin
      if (i % 10 == 0) begin
        // any field value is legal: at 25 ns a cycle four fixed cycles meet every core minimum
        {pre, sen, imp, exr} = {$urandom_range(31), $urandom_range(31),
                                $urandom_range(31), $urandom_range(31)};
        swp = $urandom_range(511);
        reg_write(row_miss_pkg::OFF_ROW_TIMING, tw());
        reg_write(row_miss_pkg::OFF_SWAP_SELECT, 32'(swp));
        reg_check(row_miss_pkg::OFF_ROW_TIMING, tw());
      end
      a = pool[$urandom_range(3)] ^ 33'($urandom_range(255));
      run(a, 1'($urandom_range(1)), 1'($urandom_range(1)), $urandom_range(7) == 0);
    end
    $display("test random done");
    print_verdict();
  end

endmodule // test_row_miss_retry_and_address_map
